// ==== logic/tio_top.sv ====
// Timer channel I/O control: counter, compare/capture, flags, bus slave
//
// How it works
// - Mode A top bit 0: compare; match holds, lowers, raises or toggles pin
// - Register A mode top bit 1: capture count on rise, fall or both
// - Mode B top bit 0: compare; match holds, lowers, raises or toggles pin
// - Register B mode top bit 1: capture count on rise, fall or both
// - Overflow flag sets when the counter wraps from all ones to zero
// - Writing 0 clears the overflow flag; writing 1 leaves it alone
// - Overflow interrupt is high one cycle after flag and its enable are both set
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module tio_top
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // Avalon-MM slave
   input  wire tio_pkg::tio_avl_req_t avs_req,
   output logic                      avs_waitrequest,
   output logic [31:0]               avs_readdata,
   // Register A pin
   input  wire logic                 pin_a_sense,
   output logic                      pin_a_drive,
   output logic                      pin_a_oe,
   // Register B pin
   input  wire logic                 pin_b_sense,
   output logic                      pin_b_drive,
   output logic                      pin_b_oe,
   // Interrupts
   output logic                      irq,
   output logic                      overflow_irq
);
   import tio_pkg::*;

   // Merge a 16-bit register with the low two byte lanes of a write
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0])
         r[7:0] = wd[7:0];
      if (be[1])
         r[15:8] = wd[15:8];
      return r;
   endfunction

   logic [7:0]        ctrl_q;
   logic [15:0]       count_q;
   logic [15:0]       gra_q;
   logic [15:0]       grb_q;
   logic [TIO_SW-1:0] status_q;
   logic [TIO_SW-1:0] status_d;
   logic [TIO_SW-1:0] mask_q;
   tio_bus_st_t       bus_q;
   logic              wait_q;
   logic [31:0]       rdata_q;
   logic [31:0]       rd_mux;
   logic              irq_q;
   logic              ovi_q;
   logic [2:0]        mode_a;
   logic [2:0]        mode_b;
   logic              rise_a, fall_a, rise_b, fall_b;
   tio_evt_t          evt_a;
   tio_evt_t          evt_b;
   logic              acc, wr;
   logic              wr_ctrl, wr_cnt, wr_gra, wr_grb;
   logic              wr_stat, wr_mask;
   logic              ovf_set;

   // Mode fields of the pin function control register
   assign mode_a = ctrl_q[TIO_A_LSB +: 3];
   assign mode_b = ctrl_q[TIO_B_LSB +: 3];

   // Pin synchronisers
   tio_pin_sync u_sync_a
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .pin_raw  (pin_a_sense),
      .rise     (rise_a),
      .fall     (fall_a)
   );

   tio_pin_sync u_sync_b
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .pin_raw  (pin_b_sense),
      .rise     (rise_b),
      .fall     (fall_b)
   );

   // Register A compare/capture
   tio_gen_chan u_chan_a
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .mode     (mode_a),
      .count    (count_q),
      .gr_val   (gra_q),
      .rise     (rise_a),
      .fall     (fall_a),
      .evt      (evt_a),
      .pin_q    (pin_a_drive),
      .pin_oe_q (pin_a_oe)
   );

   // Register B compare/capture
   tio_gen_chan u_chan_b
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .mode     (mode_b),
      .count    (count_q),
      .gr_val   (grb_q),
      .rise     (rise_b),
      .fall     (fall_b),
      .evt      (evt_b),
      .pin_q    (pin_b_drive),
      .pin_oe_q (pin_b_oe)
   );

   // Access completes in the cycle that waitrequest is low
   assign acc = (avs_req.read || avs_req.write) && (bus_q == TIO_BUS_DONE);
   assign wr  = acc && avs_req.write;

   // Write decodes; all fields sit in the low byte lanes
   assign wr_ctrl = wr && (avs_req.address == TIO_OFS_CTRL)
                    && avs_req.byteenable[0];
   assign wr_cnt  = wr && (avs_req.address == TIO_OFS_CNT);
   assign wr_gra  = wr && (avs_req.address == TIO_OFS_GRA);
   assign wr_grb  = wr && (avs_req.address == TIO_OFS_GRB);
   assign wr_stat = wr && (avs_req.address == TIO_OFS_STAT)
                    && avs_req.byteenable[0];
   assign wr_mask = wr && (avs_req.address == TIO_OFS_MASK)
                    && avs_req.byteenable[0];

   // Bus handshake: one wait cycle, then the answer
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         bus_q  <= TIO_BUS_IDLE;
         wait_q <= 1'b1;
      end
      else
      begin
         unique case (bus_q)
            TIO_BUS_IDLE:
               if (avs_req.read || avs_req.write)
               begin
                  bus_q  <= TIO_BUS_DONE;
                  wait_q <= 1'b0;
               end
            TIO_BUS_DONE:
            begin
               bus_q  <= TIO_BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (avs_req.address)
         TIO_OFS_CTRL: rd_mux[7:0]        = ctrl_q;
         TIO_OFS_CNT:  rd_mux[15:0]       = count_q;
         TIO_OFS_GRA:  rd_mux[15:0]       = gra_q;
         TIO_OFS_GRB:  rd_mux[15:0]       = grb_q;
         TIO_OFS_STAT: rd_mux[TIO_SW-1:0] = status_q;
         TIO_OFS_MASK: rd_mux[TIO_SW-1:0] = mask_q;
         default:      rd_mux             = 32'h0000_0000;
      endcase
   end

   // Read data latched while waitrequest is still high
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         rdata_q <= 32'h0000_0000;
      else if (bus_q == TIO_BUS_IDLE && avs_req.read)
         rdata_q <= rd_mux;
   end

   // Pin function control; reserved bits always read one
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         ctrl_q <= TIO_CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= (avs_req.writedata[7:0] & TIO_CTRL_WR) | TIO_CTRL_ONE;
   end

   // Free running counter; a software write replaces the step
   assign ovf_set = !wr_cnt && (count_q == TIO_CNT_MAX);

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         count_q <= TIO_CNT_RST;
      else if (wr_cnt)
         count_q <= merge16(count_q, avs_req.writedata,
                            avs_req.byteenable);
      else
         count_q <= count_q + 16'h0001;
   end

   // General register A; a capture beats a software write
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         gra_q <= TIO_GR_RST;
      else if (evt_a.cap)
         gra_q <= count_q;
      else if (wr_gra)
         gra_q <= merge16(gra_q, avs_req.writedata, avs_req.byteenable);
   end

   // General register B; a capture beats a software write
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         grb_q <= TIO_GR_RST;
      else if (evt_b.cap)
         grb_q <= count_q;
      else if (wr_grb)
         grb_q <= merge16(grb_q, avs_req.writedata, avs_req.byteenable);
   end

   // Status next value; every set wins over its clear
   always_comb
   begin
      status_d = status_q;
      // Overflow: written 0 clears, written 1 keeps
      if (wr_stat && !avs_req.writedata[TIO_ST_OVF])
         status_d[TIO_ST_OVF] = 1'b0;
      // Event bits: written 1 clears
      if (wr_stat && avs_req.writedata[TIO_ST_EVA])
         status_d[TIO_ST_EVA] = 1'b0;
      if (wr_stat && avs_req.writedata[TIO_ST_EVB])
         status_d[TIO_ST_EVB] = 1'b0;
      if (ovf_set)
         status_d[TIO_ST_OVF] = 1'b1;
      if (evt_a.hit || evt_a.cap)
         status_d[TIO_ST_EVA] = 1'b1;
      if (evt_b.hit || evt_b.cap)
         status_d[TIO_ST_EVB] = 1'b1;
   end

   // Status register
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         status_q <= TIO_ST_RST;
      else
         status_q <= status_d;
   end

   // Mask register; bit 0 is the overflow interrupt enable
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         mask_q <= TIO_MASK_RST;
      else if (wr_mask)
         mask_q <= avs_req.writedata[TIO_SW-1:0];
   end

   // Interrupt outputs, registered from flag and mask
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         irq_q <= 1'b0;
         ovi_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(status_q & mask_q);
         ovi_q <= status_q[TIO_ST_OVF] && mask_q[TIO_ST_OVF];
      end
   end

   // Outputs
   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;
   assign irq             = irq_q;
   assign overflow_irq    = ovi_q;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_req_wait;
      (avs_req.read || avs_req.write) && wait_q;
   endsequence

   sequence s_answer;
      !wait_q ##1 wait_q;
   endsequence

   a_bus_answer_once: assert property (s_req_wait |=> s_answer)
      else $error("Bus answer not one cycle after request");
   a_ovf_wrap_set: assert property (
      count_q == TIO_CNT_MAX && !wr_cnt |=>
      count_q == TIO_CNT_RST && status_q[TIO_ST_OVF])
      else $error("Overflow flag not set on wrap");
   a_ovf_zero_clear: assert property (
      wr_stat && !avs_req.writedata[TIO_ST_OVF] && !ovf_set
      |=> !status_q[TIO_ST_OVF])
      else $error("Writing 0 did not clear overflow flag");
   a_ovf_one_keeps: assert property (
      status_q[TIO_ST_OVF] && wr_stat && avs_req.writedata[TIO_ST_OVF]
      |=> status_q[TIO_ST_OVF])
      else $error("Writing 1 changed overflow flag");
   a_ovi_follows_flag: assert property (
      status_q[TIO_ST_OVF] && mask_q[TIO_ST_OVF] |=> overflow_irq)
      else $error("Overflow interrupt missing");
   a_ovi_enable_off: assert property (
      !mask_q[TIO_ST_OVF] |=> !overflow_irq)
      else $error("Overflow interrupt raised while disabled");
   a_cmp_a_low: assert property (
      mode_a == TIO_CMP_LOW && evt_a.hit |=> !pin_a_drive && pin_a_oe)
      else $error("Register A match did not drive low");
   a_cmp_a_toggle: assert property (
      mode_a == TIO_CMP_TOG && evt_a.hit
      |=> pin_a_drive != $past(pin_a_drive))
      else $error("Register A match did not toggle");
   a_cmp_b_high: assert property (
      mode_b == TIO_CMP_HIGH && evt_b.hit |=> pin_b_drive && pin_b_oe)
      else $error("Register B match did not drive high");
   a_cmp_b_none: assert property (
      mode_b == TIO_CMP_NONE && evt_b.hit |=> $stable(pin_b_drive))
      else $error("Register B no-action match moved the pin");
   a_cap_a_rise: assert property (
      mode_a == TIO_CAP_RISE && rise_a |=> gra_q == $past(count_q))
      else $error("Register A missed rising capture");
   a_cap_a_nofall: assert property (
      mode_a == TIO_CAP_RISE && fall_a && !wr_gra |=> $stable(gra_q))
      else $error("Register A captured the wrong edge");
   a_cap_b_fall: assert property (
      mode_b == TIO_CAP_FALL && fall_b |=> grb_q == $past(count_q))
      else $error("Register B missed falling capture");
   a_cap_b_both: assert property (
      mode_b == TIO_CAP_BOTH && (rise_b || fall_b)
      |=> grb_q == $past(count_q))
      else $error("Register B missed a both-edge capture");
   a_cap_odd_both: assert property (
      mode_a == TIO_CAP_ODD && (rise_a || fall_a)
      |=> gra_q == $past(count_q) && !pin_a_oe)
      else $error("Code 111 did not capture on both edges");
endmodule
`default_nettype wire

// ==== logic/tio_pkg.sv ====
// Shared constants and types of the timer channel I/O block
package tio_pkg;
   // Counter and address widths
   localparam int          TIO_CW       = 16;
   localparam int          TIO_AW       = 5;
   // Register byte offsets
   localparam logic [4:0]  TIO_OFS_CTRL = 5'h00;
   localparam logic [4:0]  TIO_OFS_CNT  = 5'h04;
   localparam logic [4:0]  TIO_OFS_GRA  = 5'h08;
   localparam logic [4:0]  TIO_OFS_GRB  = 5'h0c;
   localparam logic [4:0]  TIO_OFS_STAT = 5'h10;
   localparam logic [4:0]  TIO_OFS_MASK = 5'h14;
   // Pin function control layout
   localparam int          TIO_A_LSB    = 0;
   localparam int          TIO_B_LSB    = 4;
   localparam int          TIO_CAP_BIT  = 2;
   localparam logic [7:0]  TIO_CTRL_RST = 8'h88;
   localparam logic [7:0]  TIO_CTRL_ONE = 8'h88;
   localparam logic [7:0]  TIO_CTRL_WR  = 8'h77;
   // Mode codes of one general register
   localparam logic [2:0]  TIO_CMP_NONE = 3'h0;
   localparam logic [2:0]  TIO_CMP_LOW  = 3'h1;
   localparam logic [2:0]  TIO_CMP_HIGH = 3'h2;
   localparam logic [2:0]  TIO_CMP_TOG  = 3'h3;
   localparam logic [2:0]  TIO_CAP_RISE = 3'h4;
   localparam logic [2:0]  TIO_CAP_FALL = 3'h5;
   localparam logic [2:0]  TIO_CAP_BOTH = 3'h6;
   localparam logic [2:0]  TIO_CAP_ODD  = 3'h7;
   // Status and mask layout
   localparam int          TIO_ST_OVF   = 0;
   localparam int          TIO_ST_EVA   = 1;
   localparam int          TIO_ST_EVB   = 2;
   localparam int          TIO_SW       = 3;
   // Reset values and counter maximum
   localparam logic [15:0] TIO_CNT_RST  = 16'h0000;
   localparam logic [15:0] TIO_CNT_MAX  = 16'hffff;
   localparam logic [15:0] TIO_GR_RST   = 16'hffff;
   localparam logic [2:0]  TIO_ST_RST   = 3'h0;
   localparam logic [2:0]  TIO_MASK_RST = 3'h0;
   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } tio_avl_req_t;
   // Per register compare match and capture events
   typedef struct packed {
      logic hit;
      logic cap;
   } tio_evt_t;
   // Bus answer state
   typedef enum logic {TIO_BUS_IDLE, TIO_BUS_DONE} tio_bus_st_t;
endpackage

// ==== logic/tio_pin_sync.sv ====
// Three stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module tio_pin_sync
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Pin and edges
   input  wire logic pin_raw,
   output logic      rise,
   output logic      fall
);
   logic s1_q, s2_q, s3_q, lvl_q;

   // Chain; only s2 reads s1
   always_ff @(posedge core_clk)
   begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // Level moves only once stages two and three agree
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         lvl_q <= 1'b0;
      else if (s2_q == s3_q)
         lvl_q <= s3_q;
   end

   // Edge pulses, one cycle each
   assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
   assign fall = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule
`default_nettype wire

// ==== logic/tio_gen_chan.sv ====
// Compare and capture decision for one general register
`timescale 1ns/10ps
`default_nettype none
module tio_gen_chan
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // Mode and values
   input  wire logic [2:0]       mode,
   input  wire logic [15:0]      count,
   input  wire logic [15:0]      gr_val,
   // Synchronised pin edges
   input  wire logic             rise,
   input  wire logic             fall,
   // Events and pin drive
   output tio_pkg::tio_evt_t     evt,
   output logic                  pin_q,
   output logic                  pin_oe_q
);
   import tio_pkg::*;
   logic cap_mode, edge_hit;

   // Edge selection; code 11 counts both edges like 10
   always_comb
   begin
      cap_mode = mode[TIO_CAP_BIT];
      unique case (mode[1:0])
         2'h0:    edge_hit = rise;
         2'h1:    edge_hit = fall;
         default: edge_hit = rise | fall;
      endcase
   end

   // Match only in compare mode, capture only in capture mode
   assign evt.hit = !cap_mode && (count == gr_val);
   assign evt.cap = cap_mode && edge_hit;

   // Pin action on match
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         pin_q <= 1'b0;
      else if (evt.hit)
      begin
         unique case (mode[1:0])
            2'h0: pin_q <= pin_q;
            2'h1: pin_q <= 1'b0;
            2'h2: pin_q <= 1'b1;
            2'h3: pin_q <= !pin_q;
         endcase
      end
   end

   // Drive the pin while in compare mode
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         pin_oe_q <= 1'b0;
      else
         pin_oe_q <= !cap_mode;
   end
endmodule
`default_nettype wire

// ==== bench/tio_pin_model.sv ====
// External pin model: capture input levels and the shared wire of each pin
`timescale 1ns/10ps
`default_nettype none
module tio_pin_model
(
   // Levels the outside world puts on each pin
   input  wire logic lvl_a,
   input  wire logic lvl_b,
   // Pin drive from the block
   input  wire logic pin_a_drive,
   input  wire logic pin_a_oe,
   input  wire logic pin_b_drive,
   input  wire logic pin_b_oe,
   // Wire levels seen by the block
   output logic      pin_a_sense,
   output logic      pin_b_sense
);
   // The block owns the wire while it drives, else the outside level stands
   assign pin_a_sense = pin_a_oe ? pin_a_drive : lvl_a;
   assign pin_b_sense = pin_b_oe ? pin_b_drive : lvl_b;
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench of the timer channel I/O block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; \
   if ((g) !== (e)) begin errors++; \
   $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
   import tio_pkg::*;
   // Clock, reset and bus
   logic         core_clk;
   logic         sys_rst;
   tio_avl_req_t avs_req;
   logic         avs_waitrequest;
   logic [31:0]  avs_readdata;
   // Pins
   logic         pin_a_sense;
   logic         pin_a_drive;
   logic         pin_a_oe;
   logic         pin_b_sense;
   logic         pin_b_drive;
   logic         pin_b_oe;
   logic         lvl_a;
   logic         lvl_b;
   logic         irq;
   logic         overflow_irq;
   // Bench state
   logic         wr_s;
   logic [31:0]  rd_s;
   logic [31:0]  rd;
   logic [31:0]  exp;
   logic [2:0]   md;
   logic         hit;
   int           errors;
   int           checks;
   int           cycles = 0;
   logic [2:0]   seq_mode [5];
   logic         seq_pin  [5];

   tio_top i_dut
   (
      .core_clk        (core_clk),
      .sys_rst         (sys_rst),
      .avs_req         (avs_req),
      .avs_waitrequest (avs_waitrequest),
      .avs_readdata    (avs_readdata),
      .pin_a_sense     (pin_a_sense),
      .pin_a_drive     (pin_a_drive),
      .pin_a_oe        (pin_a_oe),
      .pin_b_sense     (pin_b_sense),
      .pin_b_drive     (pin_b_drive),
      .pin_b_oe        (pin_b_oe),
      .irq             (irq),
      .overflow_irq    (overflow_irq)
   );

   tio_pin_model i_pins
   (
      .lvl_a       (lvl_a),
      .lvl_b       (lvl_b),
      .pin_a_drive (pin_a_drive),
      .pin_a_oe    (pin_a_oe),
      .pin_b_drive (pin_b_drive),
      .pin_b_oe    (pin_b_oe),
      .pin_a_sense (pin_a_sense),
      .pin_b_sense (pin_b_sense)
   );

   // Clock of 4 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Settled copies of the answer, valid at the next rising edge
   always @(negedge core_clk)
   begin
      wr_s <= avs_waitrequest;
      rd_s <= avs_readdata;
   end

   // Cut a hang short
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         test_done();
      end
   end

   // Verdict and end of run
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One line as each test ends
   task automatic test_end(input string s);
      $display("Test %s finished at %0t", s, $time);
   endtask

   // Bus write: hold until waitrequest is seen low at a rising edge
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_req <= '{read: 1'b0, write: 1'b1, address: a, writedata: d,
                   byteenable: 4'hf};
      do
         @(posedge core_clk);
      while (wr_s !== 1'b0);
      avs_req.write <= 1'b0;
   endtask

   // Bus read: data taken at the edge that sees waitrequest low
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_req <= '{read: 1'b1, write: 1'b0, address: a, writedata: 32'h0,
                   byteenable: 4'hf};
      do
         @(posedge core_clk);
      while (wr_s !== 1'b0);
      d = rd_s;
      avs_req.read <= 1'b0;
   endtask

   // Read and compare
   task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus_rd(a, d);
      `CHK(d, e)
   endtask

   // Let cycles pass, then stop where outputs are settled
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // Main sequence
   initial
   begin
      sys_rst = 1'b1;
      avs_req = '0;
      lvl_a = 1'b0;
      lvl_b = 1'b0;
      errors = 0;
      checks = 0;
      seq_mode = '{TIO_CMP_HIGH, TIO_CMP_NONE, TIO_CMP_LOW, TIO_CMP_TOG,
                   TIO_CMP_TOG};
      seq_pin = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Reset values, fixed bits, unmapped place, counter snapshot
      chk_rd(TIO_OFS_CTRL, 32'h88);
      chk_rd(TIO_OFS_GRA, 32'hffff);
      chk_rd(TIO_OFS_STAT, 32'h0);
      chk_rd(TIO_OFS_MASK, 32'h0);
      chk_rd(5'h18, 32'h0);
      bus_wr(TIO_OFS_CTRL, 32'h0);
      chk_rd(TIO_OFS_CTRL, 32'h88);
      bus_wr(TIO_OFS_CNT, 32'h1000);
      chk_rd(TIO_OFS_CNT, 32'h1001);
      test_end("registers");
      // Compare actions on both registers, each code once and toggle a second time
      bus_wr(TIO_OFS_GRA, 32'h40);
      bus_wr(TIO_OFS_GRB, 32'h50);
      for (int i = 0; i < 5; i++)
      begin
         bus_wr(TIO_OFS_CTRL, {24'h0, 1'b0, seq_mode[i], 1'b0, seq_mode[i]});
         bus_wr(TIO_OFS_CNT, 32'h0);
         wait_n(100);
         `CHK(pin_a_drive, seq_pin[i])
         `CHK(pin_b_drive, seq_pin[i])
         `CHK({pin_a_oe, pin_b_oe}, 2'b11)
      end
      test_end("compare");
      // Capture on each edge for every capture code
      for (int c = 4; c < 8; c++)
      begin
         md = 3'(c);
         bus_wr(TIO_OFS_CTRL, {24'h0, 1'b0, md, 1'b0, md});
         for (int e = 0; e < 2; e++)
         begin
            bus_wr(TIO_OFS_GRA, 32'h1234);
            bus_wr(TIO_OFS_GRB, 32'h1234);
            bus_wr(TIO_OFS_CNT, 32'h2000);
            lvl_a <= ~lvl_a;
            lvl_b <= ~lvl_b;
            wait_n(10);
            hit = (e == 0) ? (md != TIO_CAP_FALL) : (md != TIO_CAP_RISE);
            exp = hit ? 32'h2003 : 32'h1234;
            chk_rd(TIO_OFS_GRA, exp);
            chk_rd(TIO_OFS_GRB, exp);
         end
         // Look at the enables away from the edge that launches them
         wait_n(0);
         `CHK({pin_a_oe, pin_b_oe}, 2'b00)
      end
      test_end("capture");
      // Overflow flag, its interrupt, write-one ignored, write-zero clears
      bus_wr(TIO_OFS_STAT, 32'h7);
      bus_wr(TIO_OFS_CNT, 32'hfff0);
      wait_n(30);
      bus_rd(TIO_OFS_STAT, rd);
      `CHK(rd[0], 1'b1)
      wait_n(0);
      `CHK(overflow_irq, 1'b0)
      bus_wr(TIO_OFS_MASK, 32'h1);
      wait_n(2);
      `CHK({overflow_irq, irq}, 2'b11)
      bus_wr(TIO_OFS_STAT, 32'h1);
      bus_rd(TIO_OFS_STAT, rd);
      `CHK(rd[0], 1'b1)
      bus_wr(TIO_OFS_STAT, 32'h6);
      wait_n(2);
      `CHK({overflow_irq, irq}, 2'b00)
      chk_rd(TIO_OFS_STAT, 32'h0);
      test_end("overflow");
      test_done();
   end
endmodule
`default_nettype wire
